// ==== design/acmp_ctrl.sv ====
// comparator control: axi4-lite registers, input select, sync, irq flag
// assumes one clock, synchronous active-low reset, analog core outside
//
// Behaviour
// RULE_01 - result high when positive above negative
// RULE_02 - result synchronised, one to two cycles
// RULE_03 - mux on, converter off: channel negative
// RULE_04 - otherwise external negative pin used
// RULE_05 - bandgap bit picks internal positive reference
// RULE_06 - disable bit powers comparator off, resets zero
// RULE_07 - mode: toggle, falling, rising, one reserved
// RULE_08 - flag set on selected event
// RULE_09 - flag clears on vector or written one
// RULE_10 - request when flag, enable, global enable
// RULE_11 - capture enable routes result to timer
// RULE_12 - software disables irq before disable change
// RULE_13 - software disables irq before mode change
// RULE_14 - software also enables timer capture irq
// RULE_15 - mux enable bit three, resets zero
// RULE_16 - edge detect on synced result, reserved none
`timescale 1ns/10ps
`include "acmp_consts.svh"
module acmp_ctrl
  import acmp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_out,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic comparator_power_down,
  output logic use_bandgap,
  output logic use_neg_pin,
  output logic [7:0] neg_chan_onehot,
  output logic capture_trigger,
  output logic compare_irq
);
  // register state
  logic [7:0] sfio_ff, nxt_sfio;
  logic [7:0] csr_ff, nxt_csr;
  logic [7:0] conv_ff, nxt_conv;
  // write channel state
  wr_state_t wst_ff, nxt_wst;
  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [3:0] waddr_ff, nxt_waddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wlane_ff, nxt_wlane;
  logic [1:0] bresp_ff, nxt_bresp;
  // read channel state
  rd_state_t rst_ff, nxt_rst;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  logic aw_take, w_take, wr_fire, wr_hit_csr, flag_set, flag_clr;
  logic [3:0] aw_idx, ar_idx, wa;
  logic [7:0] wd;
  logic wl;

  acmp_evt_if evt ();

  acmp_sync_edge u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(evt.det)
  );

  acmp_in_select u_sel (
    .neg_mux_enable(sfio_ff[`ACMP_BIT_NEG_MUX]),
    .converter_enable(conv_ff[`ACMP_BIT_CONV_EN]),
    .bandgap_select(csr_ff[`ACMP_BIT_BANDGAP]),
    .channel_select(conv_ff[`ACMP_CHAN_HI:`ACMP_CHAN_LO]),
    .use_bandgap(use_bandgap),
    .use_neg_pin(use_neg_pin),
    .neg_chan_onehot(neg_chan_onehot)
  );

  // core output is high while positive exceeds negative
  assign evt.raw_result = comparator_out; // RULE_01
  assign evt.powered = ~csr_ff[`ACMP_BIT_DISABLE];
  assign evt.mode = csr_ff[`ACMP_BIT_MODE_HI:`ACMP_BIT_MODE_LO];

  assign comparator_power_down = csr_ff[`ACMP_BIT_DISABLE]; // RULE_06
  assign capture_trigger = csr_ff[`ACMP_BIT_CAPT] & evt.result; // RULE_11
  assign compare_irq = csr_ff[`ACMP_BIT_FLAG] & csr_ff[`ACMP_BIT_IRQ_EN]
    & global_irq_enable; // RULE_10

  assign aw_idx = s_axi_awaddr[3:0];
  assign ar_idx = s_axi_araddr[3:0];

  // write address/data capture
  always_comb begin
    aw_take = (wst_ff == WR_IDLE) && !aw_got_ff && s_axi_awvalid;
    w_take = (wst_ff == WR_IDLE) && !w_got_ff && s_axi_wvalid;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wlane = wlane_ff;
    nxt_wst = wst_ff;
    nxt_bresp = bresp_ff;
    wr_fire = 1'b0;
    if (aw_take) begin
      nxt_aw_got = 1'b1;
      nxt_waddr = aw_idx;
    end
    if (w_take) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wlane = s_axi_wstrb[0];
    end
    case (wst_ff)
      WR_IDLE: begin
        if (nxt_aw_got && nxt_w_got) begin
          wr_fire = 1'b1;
          nxt_wst = WR_RESP;
          nxt_aw_got = 1'b0;
          nxt_w_got = 1'b0;
          nxt_bresp = (nxt_waddr == `ACMP_OFF_SFIO || nxt_waddr == `ACMP_OFF_CSR
            || nxt_waddr == `ACMP_OFF_CONV || nxt_waddr == `ACMP_OFF_ACK)
            ? `ACMP_RESP_OKAY : `ACMP_RESP_SLVERR;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wst = WR_IDLE;
        end
      end
      default: nxt_wst = WR_IDLE;
    endcase
  end

  // register file next values
  always_comb begin
    wa = nxt_waddr;
    wd = nxt_wdata;
    wl = nxt_wlane;
    nxt_sfio = sfio_ff;
    nxt_conv = conv_ff;
    nxt_csr = csr_ff;
    wr_hit_csr = wr_fire && wl && (wa == `ACMP_OFF_CSR);
    if (wr_fire && wl && wa == `ACMP_OFF_SFIO) begin
      nxt_sfio = wd & `ACMP_SFIO_WMASK; // RULE_15
    end
    if (wr_fire && wl && wa == `ACMP_OFF_CONV) begin
      nxt_conv = wd;
    end
    if (wr_hit_csr) begin
      nxt_csr[`ACMP_BIT_DISABLE] = wd[`ACMP_BIT_DISABLE]; // RULE_06
      nxt_csr[`ACMP_BIT_BANDGAP] = wd[`ACMP_BIT_BANDGAP];
      nxt_csr[`ACMP_BIT_IRQ_EN] = wd[`ACMP_BIT_IRQ_EN];
      nxt_csr[`ACMP_BIT_CAPT] = wd[`ACMP_BIT_CAPT];
      nxt_csr[`ACMP_BIT_MODE_HI:`ACMP_BIT_MODE_LO] =
        wd[`ACMP_BIT_MODE_HI:`ACMP_BIT_MODE_LO];
    end
    // write-one clear, vector acknowledge; a new event wins over both
    flag_clr = (wr_hit_csr && wd[`ACMP_BIT_FLAG]) || irq_vector_taken
      || (wr_fire && wl && wa == `ACMP_OFF_ACK && wd[`ACMP_BIT_FLAG]); // RULE_09
    flag_set = evt.event_hit; // RULE_08
    if (flag_set) begin
      nxt_csr[`ACMP_BIT_FLAG] = 1'b1;
    end else if (flag_clr) begin
      nxt_csr[`ACMP_BIT_FLAG] = 1'b0;
    end
    nxt_csr[`ACMP_BIT_RESULT] = 1'b0;
  end

  // read channel
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    case (rst_ff)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          nxt_rst = RD_RESP;
          nxt_rresp = `ACMP_RESP_OKAY;
          case (ar_idx)
            `ACMP_OFF_SFIO: nxt_rdata = {24'h000000, sfio_ff};
            `ACMP_OFF_CSR: begin
              nxt_rdata = {24'h000000, csr_ff};
              nxt_rdata[`ACMP_BIT_RESULT] = evt.result; // RULE_02
            end
            `ACMP_OFF_CONV: nxt_rdata = {24'h000000, conv_ff};
            `ACMP_OFF_ACK: nxt_rdata = 32'h00000000;
            default: begin
              nxt_rdata = 32'h00000000;
              nxt_rresp = `ACMP_RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          nxt_rst = RD_IDLE;
        end
      end
      default: nxt_rst = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sfio_ff <= `ACMP_SFIO_RESET;
      csr_ff <= `ACMP_CSR_RESET;
      conv_ff <= `ACMP_CONV_RESET;
      wst_ff <= WR_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 4'h0;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bresp_ff <= `ACMP_RESP_OKAY;
      rst_ff <= RD_IDLE;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `ACMP_RESP_OKAY;
    end else begin
      sfio_ff <= nxt_sfio;
      csr_ff <= nxt_csr;
      conv_ff <= nxt_conv;
      wst_ff <= nxt_wst;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wlane_ff <= nxt_wlane;
      bresp_ff <= nxt_bresp;
      rst_ff <= nxt_rst;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_awready = (wst_ff == WR_IDLE) && !aw_got_ff;
  assign s_axi_wready = (wst_ff == WR_IDLE) && !w_got_ff;
  assign s_axi_bvalid = (wst_ff == WR_RESP);
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = (rst_ff == RD_IDLE);
  assign s_axi_rvalid = (rst_ff == RD_RESP);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule // acmp_ctrl

// ==== design/acmp_consts.svh ====
// constants for the comparator control block: offsets, bit positions, resets
// assumes inclusion by bare name from the package and the modules
`ifndef ACMP_CONSTS_SVH
`define ACMP_CONSTS_SVH
`define ACMP_OFF_SFIO 4'h0
`define ACMP_OFF_CSR 4'h4
`define ACMP_OFF_CONV 4'h8
`define ACMP_OFF_ACK 4'hC
`define ACMP_SFIO_RESET 8'h00
`define ACMP_CSR_RESET 8'h00
`define ACMP_CONV_RESET 8'h00
`define ACMP_BIT_MODE_LO 0
`define ACMP_BIT_MODE_HI 1
`define ACMP_BIT_CAPT 2
`define ACMP_BIT_IRQ_EN 3
`define ACMP_BIT_FLAG 4
`define ACMP_BIT_RESULT 5
`define ACMP_BIT_BANDGAP 6
`define ACMP_BIT_DISABLE 7
`define ACMP_BIT_NEG_MUX 3
`define ACMP_SFIO_WMASK 8'hEF
`define ACMP_BIT_CONV_EN 3
`define ACMP_CHAN_LO 0
`define ACMP_CHAN_HI 2
`define ACMP_RESP_OKAY 2'h0
`define ACMP_RESP_SLVERR 2'h2
`endif

// ==== design/acmp_pkg.sv ====
// types shared by the comparator control block
// assumes acmp_consts.svh is on the include path
`include "acmp_consts.svh"
package acmp_pkg;
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALL = 2'h2,
    MODE_RISE = 2'h3
  } irq_mode_t;
  typedef enum {WR_IDLE, WR_RESP} wr_state_t;
  typedef enum {RD_IDLE, RD_RESP} rd_state_t;
endpackage

// ==== design/acmp_evt_if.sv ====
// carrier between the edge detector and the register file
// assumes one clock domain
`timescale 1ns/10ps
interface acmp_evt_if;
  logic raw_result;
  logic powered;
  logic [1:0] mode;
  logic result;
  logic event_hit;
  modport det (input raw_result, input powered, input mode, output result, output event_hit);
  modport regs (output raw_result, output powered, output mode, input result, input event_hit);
endinterface

// ==== design/acmp_sync_edge.sv ====
// synchroniser and event detector for the comparator result
// assumes raw_result is asynchronous to aclk
`timescale 1ns/10ps
module acmp_sync_edge
  import acmp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  acmp_evt_if.det evt
);
  logic meta_ff, nxt_meta;
  logic sync_ff, nxt_sync;
  logic prev_ff, nxt_prev;
  logic hit;

  always_comb begin
    nxt_meta = evt.raw_result & evt.powered;
    nxt_sync = meta_ff; // RULE_02
    nxt_prev = sync_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  always_comb begin
    case (irq_mode_t'(evt.mode)) // RULE_16
      MODE_TOGGLE: hit = sync_ff ^ prev_ff; // RULE_07
      MODE_FALL: hit = prev_ff & ~sync_ff;
      MODE_RISE: hit = sync_ff & ~prev_ff;
      default: hit = 1'b0;
    endcase
  end

  assign evt.result = sync_ff;
  assign evt.event_hit = hit;
endmodule // acmp_sync_edge

// ==== design/acmp_in_select.sv ====
// analog input selection controls for the comparator core
// assumes the core decodes one-hot channel enables
`timescale 1ns/10ps
module acmp_in_select
  import acmp_pkg::*;
(
  input wire logic neg_mux_enable,
  input wire logic converter_enable,
  input wire logic bandgap_select,
  input wire logic [2:0] channel_select,
  output logic use_bandgap,
  output logic use_neg_pin,
  output logic [7:0] neg_chan_onehot
);
  logic borrow;
  assign borrow = neg_mux_enable & ~converter_enable;
  assign use_neg_pin = ~borrow; // RULE_04
  assign use_bandgap = bandgap_select; // RULE_05
  for (genvar i = 0; i < 8; i++) begin : g_chan
    assign neg_chan_onehot[i] = borrow && (channel_select == 3'(i)); // RULE_03
  end
endmodule // acmp_in_select

// ==== dv/acmp_ctrl_chk.sv ====
// port checker for the comparator control block
// assumes bind to acmp_ctrl, one clock, sync low reset
`timescale 1ns/10ps
module acmp_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_out,
  input wire logic global_irq_enable,
  input wire logic comparator_power_down,
  input wire logic use_neg_pin,
  input wire logic [7:0] neg_chan_onehot,
  input wire logic capture_trigger,
  input wire logic compare_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst;
    disable iff (1'b0) !aresetn |=> !comparator_power_down && use_neg_pin && !compare_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_irq; compare_irq |-> global_irq_enable; endproperty
  a_irq: assert property (p_irq) else $error("irq without global enable");
  property p_capt; $rose(capture_trigger) |-> $past(comparator_out, 2); endproperty
  a_capt: assert property (p_capt) else $error("capture without result");
  property p_mux; !use_neg_pin |-> $onehot(neg_chan_onehot); endproperty
  a_mux: assert property (p_mux) else $error("channel not one-hot");
  property p_pin; use_neg_pin |-> neg_chan_onehot == 8'h00; endproperty
  a_pin: assert property (p_pin) else $error("channel with pin");
  property p_bst; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bst: assert property (p_bst) else $error("bvalid dropped");
  property p_rst2; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rst2: assert property (p_rst2) else $error("rvalid dropped");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_irq: cover property ($rose(compare_irq));
  c_capt: cover property ($rose(capture_trigger));
endmodule // acmp_ctrl_chk

// ==== dv/acmp_core_model.sv ====
// analog comparator core model driven by the select controls
// assumes levels are unsigned codes standing in for voltages
`timescale 1ns/10ps
module acmp_core_model #(
  parameter logic [7:0] BANDGAP_LVL = 8'h80,
  parameter logic [7:0] CHAN_LVL = 8'hC0
) (
  input wire logic [7:0] pos_lvl,
  input wire logic [7:0] neg_lvl,
  input wire logic comparator_power_down,
  input wire logic use_bandgap,
  input wire logic use_neg_pin,
  input wire logic [7:0] neg_chan_onehot,
  output logic comparator_out
);
  logic [7:0] p;
  logic [7:0] n;
  assign p = use_bandgap ? BANDGAP_LVL : pos_lvl;
  assign n = use_neg_pin ? neg_lvl : CHAN_LVL;
  // unpowered core reads low
  assign comparator_out = !comparator_power_down && (p > n);
endmodule // acmp_core_model

// ==== dv/tb.sv ====
// top bench: axi4-lite register tests against a comparator core model
// assumes design, checker and model compiled first
`timescale 1ns/10ps
bind acmp_ctrl acmp_ctrl_chk i_acmp_ctrl_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .comparator_out,
  .global_irq_enable, .comparator_power_down, .use_neg_pin, .neg_chan_onehot,
  .capture_trigger, .compare_irq);
module tb;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic global_irq_enable, irq_vector_taken, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, comparator_out, comparator_power_down, use_bandgap;
  logic use_neg_pin, capture_trigger, compare_irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] neg_chan_onehot, pos_lvl, neg_lvl;
  int n_fail = 0;
  int checks_done = 0;
  always #20 aclk = ~aclk;
  acmp_ctrl i_acmp_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_out, .global_irq_enable,
    .irq_vector_taken, .comparator_power_down, .use_bandgap, .use_neg_pin, .neg_chan_onehot,
    .capture_trigger, .compare_irq);
  acmp_core_model i_acmp_core_model (.pos_lvl, .neg_lvl, .comparator_power_down, .use_bandgap,
    .use_neg_pin, .neg_chan_onehot, .comparator_out);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rresp", er, s_axi_rresp);
    chk("rdata", ed, s_axi_rdata);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {global_irq_enable, irq_vector_taken, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    pos_lvl = 8'h00;
    neg_lvl = 8'h40;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(32'h0, 8'h00, 2'h0);
    rd(32'h4, 8'h00, 2'h0);
    rd(32'h2, 8'h00, 2'h2);
    wr(32'h2, 8'hFF, 2'h2);
    rd(32'h0, 8'h00, 2'h0);
    rd(32'hC, 8'h00, 2'h0);
    wr(32'h0, 8'hFF, 2'h0);
    rd(32'h0, 8'hEF, 2'h0);
    for (int i = 0; i < 8; i++) begin
      wr(32'h8, 8'(i), 2'h0);
      chk("onehot", 8'h01 << i, neg_chan_onehot);
    end
    wr(32'h8, 8'h0F, 2'h0);
    chk("neg_pin", 1, use_neg_pin);
    wr(32'h0, 8'h00, 2'h0);
    wr(32'h8, 8'h07, 2'h0);
    chk("neg_pin", 1, use_neg_pin);
    wr(32'h4, 8'h45, 2'h0);
    repeat (4) @(posedge aclk);
    rd(32'h4, 8'h65, 2'h0);
    chk("capture", 1, capture_trigger);
    chk("bandgap", 1, use_bandgap);
    wr(32'h4, 8'h81, 2'h0);
    chk("power", 1, comparator_power_down);
    repeat (4) @(posedge aclk);
    rd(32'h4, 8'h81, 2'h0);
    chk("capture", 0, capture_trigger);
    for (int m = 0; m < 4; m++) begin
      wr(32'h4, 8'h10 | 8'(m), 2'h0);
      pos_lvl <= 8'hFF;
      repeat (4) @(posedge aclk);
      rd(32'h4, 8'h20 | 8'(m) | ((m == 0 || m == 3) ? 8'h10 : 8'h00), 2'h0);
      wr(32'h4, 8'h10 | 8'(m), 2'h0);
      pos_lvl <= 8'h00;
      repeat (4) @(posedge aclk);
      rd(32'h4, 8'(m) | ((m == 0 || m == 2) ? 8'h10 : 8'h00), 2'h0);
    end
    wr(32'h4, 8'h18, 2'h0);
    global_irq_enable <= 1'b1;
    pos_lvl <= 8'hFF;
    repeat (4) @(posedge aclk);
    chk("irq", 1, compare_irq);
    wr(32'h4, 8'h00, 2'h0);
    chk("irq", 0, compare_irq);
    wr(32'h4, 8'h08, 2'h0);
    rd(32'h4, 8'h38, 2'h0);
    global_irq_enable <= 1'b0;
    @(posedge aclk);
    chk("irq", 0, compare_irq);
    irq_vector_taken <= 1'b1;
    @(posedge aclk);
    irq_vector_taken <= 1'b0;
    rd(32'h4, 8'h28, 2'h0);
    pos_lvl <= 8'h00;
    repeat (4) @(posedge aclk);
    rd(32'h4, 8'h18, 2'h0);
    wr(32'hC, 8'h10, 2'h0);
    rd(32'h4, 8'h08, 2'h0);
    close_out();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    close_out();
  end
endmodule // tb
